// ==== adcs_pkg.sv ====
// package: constants and types for the converter sequencer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package adcs_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL0  = 8'h00;  // go, on, channel
  localparam logic [7:0] OFF_CTRL1  = 8'h04;  // port analog config
  localparam logic [7:0] OFF_CTRL2  = 8'h08;  // acquisition / clock select
  localparam logic [7:0] OFF_RESULT = 8'h0C;  // result high:low
  localparam logic [7:0] OFF_STATUS = 8'h10;  // done flag
  localparam logic [7:0] OFF_PORT   = 8'h14;  // port pin levels
  // control field positions
  localparam int BIT_ON    = 0;
  localparam int BIT_GO    = 1;
  localparam int BIT_DONE  = 0;
  localparam int CLK_LSB   = 0;
  localparam int ACQ_LSB   = 3;
  // reset values
  localparam logic [2:0] ACQ_RESET   = 3'h0;
  localparam logic [2:0] CLK_RESET   = 3'h0;
  localparam logic [3:0] CFG_ANALOG  = 4'h0;  // no pin analog, all pins read their level
  localparam logic [3:0] CFG_DIGITAL = 4'h7;  // pins 0 to 6 analog, pin 7 digital
  // timing counts
  localparam logic [3:0] CONV_PERIODS = 4'hD;  // thirteen bit periods
  localparam logic [1:0] INSTR_OSC    = 2'h3;  // instruction cycle = 4 osc, minus one
  localparam logic [1:0] WAIT_INSTR   = 2'h2;  // post-finish wait in instruction cycles
  localparam logic [1:0] AXI_OKAY     = 2'h0;
  localparam logic [1:0] AXI_SLVERR   = 2'h2;
  // sequencer states
  typedef enum logic [4:0] {
    ADCS_IDLE = 5'b00001,
    ADCS_DLY  = 5'b00010,
    ADCS_ACQ  = 5'b00100,
    ADCS_CONV = 5'b01000,
    ADCS_WAIT = 5'b10000
  } adcs_state_e;
endpackage : adcs_pkg

// ==== adcs_tick_if.sv ====
// interface: bit period tick carried from the divider to the sequencer
`timescale 1ns/100ps
interface adcs_tick_if;
  logic       run;       // divider running
  logic [2:0] clk_sel;   // conversion clock select
  logic       rc_tick;   // rc oscillator edge, already synchronised
  logic       tick;      // one-cycle bit period pulse
  modport src (input run, input clk_sel, input rc_tick, output tick);
  modport dst (output run, output clk_sel, output rc_tick, input tick);
endinterface : adcs_tick_if

// ==== adcs_div.sv ====
// module: bit period divider for the converter sequencer
`timescale 1ns/100ps
module adcs_div (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // tick channel
  adcs_tick_if.src  tk
);
  logic [5:0] cnt_r;   // oscillator period counter
  logic [5:0] lim;     // terminal count for divider
  logic       tick_r;  // registered tick

  // ----------------------------------------------------------------
  // divider select
  // ----------------------------------------------------------------
  // clock select decode
  always_comb begin
    unique case (tk.clk_sel[1:0])
      2'b00:   lim = tk.clk_sel[2] ? 6'h03 : 6'h01;
      2'b01:   lim = tk.clk_sel[2] ? 6'h0F : 6'h07;
      default: lim = tk.clk_sel[2] ? 6'h3F : 6'h1F;
    endcase
  end

  // count oscillator periods; rc mode forwards the rc edge instead
  always_ff @(posedge aclk) begin
    if (!aresetn || !tk.run) begin
      cnt_r  <= 6'h00;
      tick_r <= 1'b0;
    end else if (tk.clk_sel[1:0] == 2'b11) begin
      cnt_r  <= 6'h00;
      tick_r <= tk.rc_tick;
    end else begin
      tick_r <= (cnt_r == lim);
      cnt_r  <= (cnt_r == lim) ? 6'h00 : cnt_r + 6'h01;
    end
  end
  assign tk.tick = tick_r;

  // tick only while running
  chk_tick_run: assert property (@(posedge aclk) disable iff (!aresetn)
    !tk.run |=> !tk.tick) else $error("tick while divider stopped");
endmodule : adcs_div

// ==== adcs_top.sv ====
// module: converter acquisition/conversion sequencer with AXI4-Lite registers
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module adcs_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // power-on reset, clears result only
  input  wire logic        por_n,
  // strap and converter pins
  input  wire logic        portb_analog_reset_select,
  input  wire logic        rc_clk_pin,
  input  wire logic [11:0] sar_result,
  input  wire logic [7:0]  port_pins,
  // write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // converter analog control
  output logic             sample_en,
  output logic             conv_start
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  adcs_tick_if tk ();                      // bit period channel
  adcs_pkg::adcs_state_e state_r;          // sequencer state
  logic        on_r;                       // converter on
  logic        go_r;                       // go flag
  logic        done_r;                     // conversion done flag
  logic [3:0]  chan_r;                     // channel select, no effect on sequence
  logic [3:0]  cfg_r;                      // port analog config
  logic [2:0]  acq_sel_r;                  // acquisition time select
  logic [2:0]  clk_sel_r;                  // conversion clock select
  logic [11:0] result_r;                   // result pair
  logic [4:0]  acq_cnt_r;                  // acquisition down counter
  logic [3:0]  conv_cnt_r;                 // conversion bit counter
  logic [1:0]  osc_cnt_r;                  // instruction cycle prescaler
  logic [1:0]  wait_cnt_r;                 // post-finish wait
  logic        rc_s1_r;                    // rc pin sync stage 1
  logic        rc_s2_r;                    // rc pin sync stage 2
  logic        rc_s3_r;                    // rc edge detect
  logic [7:0]  pin_s1_r;                   // port pin sync stage 1
  logic [7:0]  pin_s2_r;                   // port pin sync stage 2
  logic        strap_done_r;               // strap captured after reset
  logic        aw_hold_r;                  // write address captured
  logic        w_hold_r;                   // write data captured
  logic [7:0]  aw_addr_r;                  // held write address
  logic [31:0] w_data_r;                   // held write data
  logic [3:0]  w_strb_r;                   // held write strobes
  logic        instr_tick;                 // one instruction cycle pulse
  logic        wr_go;                      // write accepted this cycle
  logic        wr_ctrl0;                   // write hits control 0
  logic        wr_res;                     // write hits result
  logic        go_wr_val;                  // go value written
  logic        go_abort;                   // software clears go mid-sequence
  logic        conv_end;                   // thirteenth bit period passes
  logic [4:0]  acq_load;                   // acquisition periods for select
  logic [7:0]  port_view;                  // masked port readback
  logic [31:0] rd_mux;                     // read data select
  logic        rd_ok;                      // read address decodes

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops before any logic reads the rc clock and the pins
  always_ff @(posedge aclk) begin
    rc_s1_r  <= rc_clk_pin;
    rc_s2_r  <= rc_s1_r;
    rc_s3_r  <= rc_s2_r;
    pin_s1_r <= port_pins;
    pin_s2_r <= pin_s1_r;
  end

  // ----------------------------------------------------------------
  // bit period divider
  // ----------------------------------------------------------------
  assign tk.run     = (state_r == adcs_pkg::ADCS_ACQ) || (state_r == adcs_pkg::ADCS_CONV);
  assign tk.clk_sel = clk_sel_r;
  assign tk.rc_tick = rc_s2_r & ~rc_s3_r;

  adcs_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tk      (tk)
  );

  // instruction cycle: four oscillator periods
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt_r <= 2'h0;
    end else begin
      osc_cnt_r <= osc_cnt_r + 2'h1;
    end
  end
  assign instr_tick = (osc_cnt_r == adcs_pkg::INSTR_OSC);

  // ----------------------------------------------------------------
  // bus write path
  // ----------------------------------------------------------------
  assign wr_go     = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_ctrl0  = wr_go && (aw_addr_r == adcs_pkg::OFF_CTRL0) && w_strb_r[0];
  assign wr_res    = wr_go && (aw_addr_r == adcs_pkg::OFF_RESULT);
  assign go_wr_val = w_data_r[adcs_pkg::BIT_GO];
  assign go_abort  = wr_ctrl0 && !go_wr_val && go_r;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // ready flags and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= adcs_pkg::AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_r && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r == adcs_pkg::OFF_CTRL0 || aw_addr_r == adcs_pkg::OFF_CTRL1
                      || aw_addr_r == adcs_pkg::OFF_CTRL2 || aw_addr_r == adcs_pkg::OFF_RESULT
                      || aw_addr_r == adcs_pkg::OFF_STATUS) ? adcs_pkg::AXI_OKAY
                      : adcs_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // reset turns converter off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_r   <= 1'b0;
      chan_r <= 4'h0;
    end else if (wr_ctrl0) begin
      on_r   <= w_data_r[adcs_pkg::BIT_ON];
      // channel stored only, sequence ignores it
      chan_r <= w_data_r[5:2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acq_sel_r <= adcs_pkg::ACQ_RESET;
      clk_sel_r <= adcs_pkg::CLK_RESET;
    end else if (wr_go && aw_addr_r == adcs_pkg::OFF_CTRL2 && w_strb_r[0]) begin
      acq_sel_r <= w_data_r[adcs_pkg::ACQ_LSB +: 3];
      clk_sel_r <= w_data_r[adcs_pkg::CLK_LSB +: 3];
    end
  end

  // strap caught one cycle after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r        <= adcs_pkg::CFG_ANALOG;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      cfg_r        <= portb_analog_reset_select ? adcs_pkg::CFG_ANALOG : adcs_pkg::CFG_DIGITAL;
      strap_done_r <= 1'b1;
    end else if (wr_go && aw_addr_r == adcs_pkg::OFF_CTRL1 && w_strb_r[0]) begin
      cfg_r <= w_data_r[3:0];
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // acquisition code to bit periods
  always_comb begin
    unique case (acq_sel_r)
      3'h1:    acq_load = 5'd2;
      3'h2:    acq_load = 5'd4;
      3'h3:    acq_load = 5'd6;
      3'h4:    acq_load = 5'd8;
      3'h5:    acq_load = 5'd12;
      3'h6:    acq_load = 5'd16;
      3'h7:    acq_load = 5'd20;
      default: acq_load = 5'd0;
    endcase
  end

  // thirteenth tick of conversion
  // an abort in the same cycle wins, so a cut conversion never loads the result
  assign conv_end = (state_r == adcs_pkg::ADCS_CONV) && tk.tick
                 && (conv_cnt_r == adcs_pkg::CONV_PERIODS - 4'h1) && !go_abort;

  // reset aborts sequence; only go visible
  always_ff @(posedge aclk) begin
    if (!aresetn || !on_r) begin
      state_r    <= adcs_pkg::ADCS_IDLE;
      acq_cnt_r  <= 5'd0;
      conv_cnt_r <= 4'h0;
      wait_cnt_r <= 2'h0;
    end else if (go_abort && state_r != adcs_pkg::ADCS_WAIT) begin
      state_r    <= adcs_pkg::ADCS_WAIT;
      wait_cnt_r <= 2'h0;
    end else begin
      unique case (state_r)
        adcs_pkg::ADCS_IDLE: begin
          if (go_r) begin
            conv_cnt_r <= 4'h0;
            acq_cnt_r  <= acq_load;
            // rc clock manual mode waits one instruction cycle
            if (acq_sel_r == 3'h0 && clk_sel_r[1:0] == 2'b11) begin
              state_r <= adcs_pkg::ADCS_DLY;
            end else if (acq_sel_r == 3'h0) begin
              state_r <= adcs_pkg::ADCS_CONV;
            end else begin
              state_r <= adcs_pkg::ADCS_ACQ;
            end
          end
        end
        adcs_pkg::ADCS_DLY: begin
          if (instr_tick) begin
            state_r <= adcs_pkg::ADCS_CONV;
          end
        end
        adcs_pkg::ADCS_ACQ: begin
          if (tk.tick) begin
            if (acq_cnt_r == 5'd1) begin
              state_r <= adcs_pkg::ADCS_CONV;
            end
            acq_cnt_r <= acq_cnt_r - 5'd1;
          end
        end
        adcs_pkg::ADCS_CONV: begin
          if (conv_end) begin
            state_r    <= adcs_pkg::ADCS_WAIT;
            wait_cnt_r <= 2'h0;
          end else if (tk.tick) begin
            conv_cnt_r <= conv_cnt_r + 4'h1;
          end
        end
        adcs_pkg::ADCS_WAIT: begin
          if (instr_tick) begin
            if (wait_cnt_r == adcs_pkg::WAIT_INSTR - 2'h1) begin
              state_r <= adcs_pkg::ADCS_IDLE;
            end
            wait_cnt_r <= wait_cnt_r + 2'h1;
          end
        end
      endcase
    end
  end

  // go flag: software sets, completion clears
  always_ff @(posedge aclk) begin
    if (!aresetn || !on_r) begin
      go_r <= 1'b0;
    end else if (conv_end) begin
      go_r <= 1'b0;
    end else if (wr_ctrl0 && state_r != adcs_pkg::ADCS_WAIT) begin
      go_r <= go_wr_val;
    end
  end

  // done flag: set wins over software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_r <= 1'b0;
    end else if (conv_end) begin
      done_r <= 1'b1;
    end else if (wr_go && aw_addr_r == adcs_pkg::OFF_STATUS && !w_data_r[adcs_pkg::BIT_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // result cleared only by power-on reset
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      result_r <= 12'h000;
    end else if (conv_end) begin
      result_r <= sar_result;
    end else if (wr_res && w_strb_r[0] && w_strb_r[1]) begin
      result_r <= w_data_r[11:0];
    end
  end

  // analog control outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_en  <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      // a programmed acquisition keeps sampling through the go cycle
      sample_en  <= on_r && ((state_r == adcs_pkg::ADCS_IDLE
                   && (!go_r || acq_sel_r != adcs_pkg::ACQ_RESET))
                   || state_r == adcs_pkg::ADCS_ACQ);
      conv_start <= (state_r != adcs_pkg::ADCS_CONV) && (state_r != adcs_pkg::ADCS_WAIT)
                 && on_r && go_r && !go_abort;
    end
  end

  // ----------------------------------------------------------------
  // bus read path
  // ----------------------------------------------------------------
  // analog-configured pins read zero
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port_view[i] = (i >= int'(cfg_r)) ? pin_s2_r[i] : 1'b0;
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      adcs_pkg::OFF_CTRL0:  rd_mux = {26'h0, chan_r, go_r, on_r};
      adcs_pkg::OFF_CTRL1:  rd_mux = {28'h0, cfg_r};
      adcs_pkg::OFF_CTRL2:  rd_mux = {26'h0, acq_sel_r, clk_sel_r};
      adcs_pkg::OFF_RESULT: rd_mux = {20'h0, result_r};
      adcs_pkg::OFF_STATUS: rd_mux = {31'h0, done_r};
      adcs_pkg::OFF_PORT:   rd_mux = {24'h0, port_view};
      default:              rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= adcs_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? adcs_pkg::AXI_OKAY : adcs_pkg::AXI_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_conv_thirteen: assert property (@(posedge aclk) disable iff (!aresetn || !on_r)
    (state_r == adcs_pkg::ADCS_CONV && tk.tick && !go_abort
     && conv_cnt_r != adcs_pkg::CONV_PERIODS - 4'h1) |=> state_r == adcs_pkg::ADCS_CONV)
    else $error("conversion ended before thirteen periods");
  chk_done_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_end |=> done_r && !go_r) else $error("completion did not set done");
  chk_manual_start: assert property (@(posedge aclk) disable iff (!aresetn || !on_r)
    (state_r == adcs_pkg::ADCS_IDLE && go_r && acq_sel_r == 3'h0
     && clk_sel_r[1:0] != 2'b11 && !go_abort) |=> state_r == adcs_pkg::ADCS_CONV)
    else $error("manual start not immediate");
  chk_prog_acq: assert property (@(posedge aclk) disable iff (!aresetn || !on_r)
    (state_r == adcs_pkg::ADCS_IDLE && go_r && acq_sel_r != 3'h0 && !go_abort)
    |=> state_r == adcs_pkg::ADCS_ACQ) else $error("programmed acquisition skipped");
  chk_rc_delay: assert property (@(posedge aclk) disable iff (!aresetn || !on_r)
    (state_r == adcs_pkg::ADCS_IDLE && go_r && acq_sel_r == 3'h0
     && clk_sel_r[1:0] == 2'b11 && !go_abort) |=> state_r == adcs_pkg::ADCS_DLY)
    else $error("rc manual start not delayed");
  chk_abort_hold: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
    (go_abort && !wr_res) |=> $stable(result_r)) else $error("abort changed result");
  chk_wait_exit: assert property (@(posedge aclk) disable iff (!aresetn || !on_r)
    (state_r == adcs_pkg::ADCS_WAIT && $past(state_r) != adcs_pkg::ADCS_WAIT)
    |-> ##[1:9] state_r == adcs_pkg::ADCS_IDLE) else $error("wait exceeded two cycles");
  chk_acq_reset: assert property (@(posedge aclk)
    !aresetn |=> acq_sel_r == 3'h0 && !on_r) else $error("reset values wrong");
  cov_complete: cover property (@(posedge aclk) conv_end);
  cov_abort: cover property (@(posedge aclk) go_abort);
  cov_acq: cover property (@(posedge aclk) state_r == adcs_pkg::ADCS_ACQ);
endmodule : adcs_top

// ==== adcs_analog_model.sv ====
// file: behavioural converter front end: result, rc clock, port pins
`timescale 1ns/100ps
module adcs_analog_model #(
  parameter logic [11:0] CODE    = 12'hA5C,  // value the converter reports
  parameter int          RC_HALF = 10        // rc half period in aclk cycles
) (
  // clock
  input  wire logic        aclk,
  // converter pins
  output logic             rc_clk_pin,
  output logic [11:0]      sar_result,
  output logic [7:0]       port_pins
);
  int cnt = 0;  // rc half period counter
  // rc clock runs in sleep
  // rc oscillator runs free, so its phase to a go write is unknown
  always @(posedge aclk) begin
    cnt <= (cnt == RC_HALF - 1) ? 0 : cnt + 1;
    if (cnt == RC_HALF - 1) rc_clk_pin <= ~rc_clk_pin;
  end
  initial rc_clk_pin = 1'b0;
  assign sar_result = CODE;
  // all pins high, so zeroed analog pins stand out
  assign port_pins = 8'hFF;
endmodule // adcs_analog_model

// ==== adcs_top_test.sv ====
// file: self-checking bench for the converter sequencer
`timescale 1ns/100ps
module adcs_top_test;
  logic aclk = 0, aresetn = 0, por_n = 0, portb_analog_reset_select = 1;
  logic rc_clk_pin, sample_en, conv_start;
  logic [11:0] sar_result;
  logic [7:0] port_pins, s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int miscompares = 0, num_checks = 0, hi, lo, cs;
  // every divider and rc
  // per run: clock code, bit period in clocks, acquisition code and count
  int clk_c[8] = '{0, 4, 1, 5, 2, 6, 3, 7};
  int tad[8]   = '{2, 4, 8, 16, 32, 64, 20, 20};
  int acq_c[8] = '{0, 1, 7, 3, 4, 5, 0, 6};
  int acq_n[8] = '{0, 2, 20, 6, 8, 12, 0, 16};
  always #50 aclk = ~aclk;
  adcs_top dut (.*);
  adcs_analog_model model (.*);
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a bounded wait that ran out ends the run
  task automatic bound(input int n);
    if (n > 3000) begin
      miscompares++;
      end_of_test;
    end
  endtask
  // axi write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n <= 3000);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
    bound(n);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n <= 3000);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
    bound(n);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    por_n <= 1;
    @(posedge aclk);
    rdr(adcs_pkg::OFF_CTRL2);
    chk(rd, 32'h0000_0000);
    rdr(adcs_pkg::OFF_CTRL1);
    chk(rd, 32'(adcs_pkg::CFG_ANALOG));
    rdr(8'h18);
    chk(32'(rsp), 32'(adcs_pkg::AXI_SLVERR));
    wr(adcs_pkg::OFF_PORT, 32'h0000_0000);
    chk(32'(rsp), 32'(adcs_pkg::AXI_SLVERR));
    wr(adcs_pkg::OFF_CTRL1, 32'h0000_0004);
    repeat (4) @(posedge aclk);
    rdr(adcs_pkg::OFF_PORT);
    chk(rd, 32'h0000_00F0);
    // every clock code once, each with the acquisition code from acq_c
    for (int i = 0; i < 8; i++) begin
      wr(adcs_pkg::OFF_CTRL2, 32'(acq_c[i] * 8 + clk_c[i]));
      wr(adcs_pkg::OFF_CTRL0, 32'h0000_0001);
      repeat (3 * tad[i] + 4) @(posedge aclk);
      wr(adcs_pkg::OFF_CTRL0, 32'h0000_0003);
      hi = 0;
      lo = 0;
      cs = 0;
      while (sample_en === 1'b1 && hi <= 3000) begin
        @(posedge aclk);
        hi++;
        if (conv_start === 1'b1) cs++;
      end
      while (sample_en !== 1'b1 && lo <= 3000) begin
        @(posedge aclk);
        lo++;
      end
      bound(hi);
      bound(lo);
      // divided clocks give an exact sampling count, the free rc clock only a window
      if (clk_c[i] % 4 == 3) begin
        chk(32'(hi >= (acq_n[i] > 0 ? (acq_n[i] - 1) * tad[i] + 2 : 1)), 1);
        chk(32'(hi <= acq_n[i] * tad[i] + 4), 1);
        chk(32'(lo >= 12 * tad[i] + 8 && lo <= 13 * tad[i] + 16), 1);
      end else begin
        chk(32'(hi == (acq_n[i] > 0 ? acq_n[i] * tad[i] + 3 : 1)), 1);
        chk(32'(lo >= 13 * tad[i] + 5 && lo <= 13 * tad[i] + 10), 1);
      end
      chk(32'(cs > 0 && conv_start === 1'b0), 1);
      rdr(adcs_pkg::OFF_CTRL0);
      chk(rd, 32'h0000_0001);
      rdr(adcs_pkg::OFF_STATUS);
      chk(32'(rd[0]), 1);
      rdr(adcs_pkg::OFF_RESULT);
      chk(rd, 32'h0000_0A5C);
      wr(adcs_pkg::OFF_STATUS, 32'h0000_0000);
    end
    // abort mid-conversion must leave the written result alone
    wr(adcs_pkg::OFF_RESULT, 32'h0000_0123);
    wr(adcs_pkg::OFF_CTRL2, 32'h0000_0005);
    wr(adcs_pkg::OFF_CTRL0, 32'h0000_0003);
    repeat (60) @(posedge aclk);
    wr(adcs_pkg::OFF_CTRL0, 32'h0000_0001);
    repeat (300) @(posedge aclk);
    rdr(adcs_pkg::OFF_RESULT);
    chk(rd, 32'h0000_0123);
    rdr(adcs_pkg::OFF_STATUS);
    chk(rd, 32'h0000_0000);
    rdr(adcs_pkg::OFF_CTRL0);
    chk(rd, 32'h0000_0001);
    wr(adcs_pkg::OFF_CTRL0, 32'h0000_0003);
    repeat (20) @(posedge aclk);
    aresetn <= 0;
    portb_analog_reset_select <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk(32'(sample_en), 0);
    rdr(adcs_pkg::OFF_CTRL0);
    chk(rd, 32'h0000_0000);
    rdr(adcs_pkg::OFF_CTRL1);
    chk(rd, 32'(adcs_pkg::CFG_DIGITAL));
    rdr(adcs_pkg::OFF_RESULT);
    chk(rd, 32'h0000_0123);
    rdr(adcs_pkg::OFF_CTRL2);
    chk(rd, 32'h0000_0000);
    end_of_test;
  end
endmodule // adcs_top_test
